// ==== include/svmr_pkg.sv ====
// constants, state types and helpers for the supply voltage monitor reset block
// assumes a single 125 MHz clock and an AXI4-Lite master on the register side
package svmr_pkg;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;

  // comparator_control_reg field positions
  localparam int C1_EN = 0;
  localparam int C1_RST = 1;
  localparam int C1_REL = 2;
  localparam int C1_NMI = 3;
  localparam int C2_EN = 4;
  localparam int C2_RST = 5;
  localparam int C2_REL = 6;
  localparam int C2_NMI = 7;
  localparam int C2_EXT = 8;
  localparam int C1_COND = 9;
  localparam int C2_COND = 11;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

  // event bits, shared by interrupt status and mask
  localparam int EV_CH1 = 0;
  localparam int EV_CH2 = 1;
  localparam int EV_CH0 = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  // trigger condition codes
  localparam logic [1:0] COND_RISE = 2'h0;
  localparam logic [1:0] COND_FALL = 2'h1;
  localparam logic [1:0] COND_BOTH = 2'h2;
  localparam logic [1:0] COND_BAD = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAB_US = 100;
  localparam int STAB_CYC_DEF = (STAB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic prevAbove;
    logic rst;
    logic counting;
    logic [CNT_W-1:0] cnt;
    logic level;
    logic pass;
  } svmr_chan_t;

  localparam svmr_chan_t CHAN_RST = '{prevAbove: 1'b1, rst: 1'b0, counting: 1'b0,
                                      cnt: 16'h0000, level: 1'b1, pass: 1'b0};

  // byte-lane merge for register writes
  function automatic logic [31:0] wrMerge(logic [31:0] old, logic [31:0] d, logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ==== include/svmr_chan_if.sv ====
// carrier between the control top and one monitor channel
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface svmr_chan_if;
  logic en;
  logic rstEn;
  logic relSel;
  logic above;
  logic [1:0] cond;
  logic rstReq;
  logic levelFlag;
  logic passEvt;

  modport ctrl(output en, rstEn, relSel, above, cond, input rstReq, levelFlag, passEvt);
  modport chan(input en, rstEn, relSel, above, cond, output rstReq, levelFlag, passEvt);
endinterface

// ==== rtl/svmr_channel.sv ====
// one voltage monitor channel: reset request, release delay, level flag, passage event
// assumes the comparator level arrives already synchronised to mclk
`timescale 1ns/1ps
module svmr_channel
  import svmr_pkg::*;
#(
  parameter logic [CNT_W-1:0] STAB_CYC = 16'h30d4
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  svmr_chan_if.chan ch // channel controls and results
);

  svmr_chan_t s;
  svmr_chan_t n;
  logic rose;
  logic fell;
  logic active;

  // edge detection against the previous sampled level
  assign rose = ch.above && !s.prevAbove;
  assign fell = !ch.above && s.prevAbove;
  assign active = ch.en && ch.rstEn;

  function automatic logic condHit(logic [1:0] c, logic r, logic f);
    unique case (c)
      COND_RISE: return r;
      COND_FALL: return f;
      COND_BOTH: return r || f;
      default: return 1'b0; // prohibited code triggers nothing
    endcase
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    n = s;
    n.prevAbove = ch.above;
    n.level = !ch.en || ch.above;
    n.pass = ch.en && condHit(ch.cond, rose, fell);
    if (!active) begin
      n.rst = 1'b0;
      n.counting = 1'b0;
      n.cnt = '0;
    end else if (!ch.relSel) begin
      // delay counts from recovery; any dip restarts it
      n.counting = 1'b0;
      if (!ch.above) begin
        n.rst = 1'b1;
        n.cnt = '0;
      end else if (s.rst) begin
        if (s.cnt == STAB_CYC - 16'h0001) begin
          n.rst = 1'b0;
          n.cnt = '0;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
    end else begin
      // delay counts from the latest drop; a recovery does not stop it, a new drop restarts it
      if (fell) begin
        n.rst = 1'b1;
        n.counting = 1'b1;
        n.cnt = '0;
      end else if (s.counting) begin
        if (s.cnt == STAB_CYC - 16'h0001) begin
          n.rst = 1'b0;
          n.counting = 1'b0;
          n.cnt = '0;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end else if (s.rst) begin
        n.counting = 1'b1; // mode switched while held in reset
        n.cnt = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= CHAN_RST;
    end else begin
      s <= n;
    end
  end

  assign ch.rstReq = s.rst;
  assign ch.levelFlag = s.level;
  assign ch.passEvt = s.pass;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_low_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    active && !ch.relSel && !ch.above |=> s.rst && s.cnt == 16'h0000)
    else $error("reset not held while below threshold");
  a_release_count: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(s.rst) && $past(active) |-> $past(s.cnt) == STAB_CYC - 16'h0001)
    else $error("reset released before the stabilization count");
  a_drop_start: assert property (@(posedge mclk) disable iff (!rst_n)
    active && ch.relSel && fell |=> s.rst && s.counting && s.cnt == 16'h0000)
    else $error("drop did not start the release delay");
  a_flag_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    !ch.en |=> s.level)
    else $error("level flag not 1 while disabled");
  a_flag_low: assert property (@(posedge mclk) disable iff (!rst_n)
    ch.en && !ch.above |=> !s.level)
    else $error("level flag not 0 while below");
  a_cond_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    ch.en && ch.cond == COND_RISE && rose |=> s.pass)
    else $error("rise trigger missed");
  a_cond_bad: assert property (@(posedge mclk) disable iff (!rst_n)
    ch.cond == COND_BAD |=> !s.pass)
    else $error("prohibited trigger code fired");
  cp_release: cover property (@(posedge mclk) disable iff (!rst_n) $fell(s.rst));
  cp_pass: cover property (@(posedge mclk) disable iff (!rst_n) s.pass);

endmodule

// ==== rtl/svmr_top.sv ====
// top of the supply voltage monitor reset block: AXI4-Lite registers,
// comparator synchronisers, channel 2 source select and interrupt routing
// assumes comparator outputs are asynchronous levels, high while above threshold
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module svmr_top
  import svmr_pkg::*;
#(
  parameter logic [CNT_W-1:0] STAB_CYC = CNT_W'(STAB_CYC_DEF)
) (
  input wire logic mclk, // system clock, 125 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic cmp0Above, // supply above threshold_0
  input wire logic cmp1Above, // supply above threshold_1
  input wire logic cmp2VccAbove, // supply above threshold_2
  input wire logic cmp2PinAbove, // external_compare_pin above threshold_2
  output logic rst0Req, // channel 0 reset request
  output logic rst1Req, // channel 1 reset request
  output logic rst2Req, // channel 2 reset request
  output logic nmiReq, // non-maskable interrupt request, level
  output logic irq // maskable interrupt request, level
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] intStat;
    logic [2:0] rstOut;
    logic nmi;
    logic irq;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } svmr_top_t;

  svmr_top_t s;
  svmr_top_t n;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] nmiBits;

  svmr_chan_if c0 ();
  svmr_chan_if c1 ();
  svmr_chan_if c2 ();

  // --------------------------------------------------------------
  // channels
  // --------------------------------------------------------------
  // channel 0 is always armed and releases only after recovery
  assign c0.en = 1'b1;
  assign c0.rstEn = 1'b1;
  assign c0.relSel = 1'b0;
  assign c0.cond = COND_FALL; // its drop is logged as an event
  assign c0.above = s.sync2[0];

  assign c1.en = s.ctrl[C1_EN];
  assign c1.rstEn = s.ctrl[C1_RST];
  assign c1.relSel = s.ctrl[C1_REL];
  assign c1.cond = s.ctrl[C1_COND +: 2];
  assign c1.above = s.sync2[1];

  assign c2.en = s.ctrl[C2_EN];
  assign c2.rstEn = s.ctrl[C2_RST];
  assign c2.relSel = s.ctrl[C2_REL];
  assign c2.cond = s.ctrl[C2_COND +: 2];
  // both sources are synchronised all the time, so switching is glitch free
  assign c2.above = s.ctrl[C2_EXT] ? s.sync2[3] : s.sync2[2];

  svmr_channel #(
    .STAB_CYC(STAB_CYC)
  ) u_ch0 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch(c0.chan)
  );

  svmr_channel #(
    .STAB_CYC(STAB_CYC)
  ) u_ch1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch(c1.chan)
  );

  svmr_channel #(
    .STAB_CYC(STAB_CYC)
  ) u_ch2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch(c2.chan)
  );

  assign ev = {c0.passEvt, c2.passEvt, c1.passEvt};

  // --------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------
  function automatic logic isMapped(logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_INT_STAT || a == ADDR_INT_MASK;
  endfunction

  function automatic logic [31:0] rdMux(logic [7:0] a, svmr_top_t st, logic l1, logic l2);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL: r = 32'(st.ctrl);
      ADDR_STAT: r = {27'h0, st.rstOut, l2, l1};
      ADDR_INT_STAT: r = 32'(st.intStat);
      ADDR_INT_MASK: r = 32'(st.mask);
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------
  // next state: bus slave, flags, outputs
  // --------------------------------------------------------------
  always_comb begin
    n = s;
    clr = '0;
    nmiBits = '0;
    // the first stage feeds only the second
    n.sync1 = {cmp2PinAbove, cmp2VccAbove, cmp1Above, cmp0Above};
    n.sync2 = s.sync1;

    // address and data are taken independently, in either order
    if (awvalid && s.awRdy) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wRdy) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = isMapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.awAddr == ADDR_CTRL) begin
        n.ctrl = CTRL_W'(wrMerge(32'(s.ctrl), s.wData, s.wStrb));
      end
      if (s.awAddr == ADDR_INT_MASK) begin
        n.mask = EV_W'(wrMerge(32'(s.mask), s.wData, s.wStrb));
      end
      if (s.awAddr == ADDR_INT_STAT) begin
        clr = EV_W'(wrMerge(32'h0000_0000, s.wData, s.wStrb));
      end
    end

    if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (arvalid && s.arRdy) begin
      n.rValid = 1'b1;
      n.rData = rdMux(araddr, s, c1.levelFlag, c2.levelFlag);
      n.rResp = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.awRdy = !n.awHave && !n.bValid;
    n.wRdy = !n.wHave && !n.bValid;
    n.arRdy = !n.rValid;

    // a new event in the clearing cycle survives the clear
    n.intStat = (s.intStat & ~clr) | ev;
    n.rstOut = {c2.rstReq, c1.rstReq, c0.rstReq};
    // non-maskable routing bypasses the mask on purpose
    nmiBits = {1'b0, n.ctrl[C2_NMI], n.ctrl[C1_NMI]};
    n.nmi = |(n.intStat & nmiBits);
    n.irq = |(n.intStat & n.mask & ~nmiBits);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sync1 <= 4'hf;
      s.sync2 <= 4'hf;
      s.ctrl <= CTRL_RST;
      s.mask <= MASK_RST;
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------
  // outputs, all straight from flops
  // --------------------------------------------------------------
  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arRdy;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;
  assign rst0Req = s.rstOut[0];
  assign rst1Req = s.rstOut[1];
  assign rst2Req = s.rstOut[2];
  assign nmiReq = s.nmi;
  assign irq = s.irq;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_ch1_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (s.ctrl[C1_EN] && s.ctrl[C1_RST] && !s.ctrl[C1_REL] && !cmp1Above)[*4] |=> rst1Req)
    else $error("channel 1 reset not requested while low");
  a_ch2_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (s.ctrl[C2_EN] && s.ctrl[C2_RST] && !s.ctrl[C2_REL] && !s.ctrl[C2_EXT]
     && !cmp2VccAbove)[*4] |=> rst2Req)
    else $error("channel 2 reset not requested while low");
  a_ch0_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cmp0Above)[*4] |=> rst0Req)
    else $error("channel 0 reset not requested while low");
  a_ch2_pin_path: assert property (@(posedge mclk) disable iff (!rst_n)
    (s.ctrl[C2_EXT] && s.ctrl[C2_EN] && !cmp2PinAbove)[*4] |-> !c2.levelFlag)
    else $error("channel 2 ignores the external pin");
  a_ch2_vcc_path: assert property (@(posedge mclk) disable iff (!rst_n)
    (!s.ctrl[C2_EXT] && s.ctrl[C2_EN] && !cmp2VccAbove)[*4] |-> !c2.levelFlag)
    else $error("channel 2 ignores the supply");
  a_nmi_route: assert property (@(posedge mclk) disable iff (!rst_n)
    n.intStat[EV_CH2] && n.ctrl[C2_NMI] |=> nmiReq)
    else $error("non-maskable routing lost");
  a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n)
    n.ctrl[C1_NMI] && n.ctrl[C2_NMI] && !n.intStat[EV_CH0] |=> !irq)
    else $error("maskable interrupt from a non-maskable channel");
  cp_write: cover property (@(posedge mclk) disable iff (!rst_n) s.bValid && bready);
  cp_irq: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));
  cp_nmi: cover property (@(posedge mclk) disable iff (!rst_n) $rose(nmiReq));

endmodule

// ==== sim/svmr_cmp_model.sv ====
// comparator stand-in for the four threshold comparators of the monitor
// assumes the bench sets wanted levels just after a rising edge of mclk
`timescale 1ns/1ps
module svmr_cmp_model (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] target, // wanted levels {pin, vcc2, vcc1, vcc0}
  output logic cmp0Above, // supply above threshold_0
  output logic cmp1Above, // supply above threshold_1
  output logic cmp2VccAbove, // supply above threshold_2
  output logic cmp2PinAbove // external_compare_pin above threshold_2
);
  // ------------------------------------------------------------
  // comparator outputs
  // ------------------------------------------------------------
  // one flop of delay stands for the analogue settling time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {cmp2PinAbove, cmp2VccAbove, cmp1Above, cmp0Above} <= 4'hf; // supply good at power-up
    end else begin
      {cmp2PinAbove, cmp2VccAbove, cmp1Above, cmp0Above} <= target;
    end
  end
endmodule

// ==== sim/svmr_top_bench.sv ====
// self-checking bench for the supply voltage monitor reset block
// assumes svmr_pkg is compiled first and STAB_CYC is shortened to 16
`timescale 1ns/1ps
module svmr_top_bench;
  import svmr_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk, rst_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, lvl, strb;
  logic [1:0] bresp, rresp, r;
  logic cmp0Above, cmp1Above, cmp2VccAbove, cmp2PinAbove;
  logic rst0Req, rst1Req, rst2Req, nmiReq, irq;
  logic [31:0] v;
  int nErrors = 0;
  int checkCount = 0;
  int cycles = 0;

  svmr_top #(.STAB_CYC(16'h0010)) u_dut (.mclk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cmp0Above, .cmp1Above, .cmp2VccAbove,
    .cmp2PinAbove, .rst0Req, .rst1Req, .rst2Req, .nmiReq, .irq);

  svmr_cmp_model u_cmp (.mclk, .rst_n, .target(lvl), .cmp0Above, .cmp1Above,
    .cmp2VccAbove, .cmp2PinAbove);

  // ------------------------------------------------------------
  // clock and timeout
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // whole run is well under a thousand cycles, so this only trips on a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      reportAndStop();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    bit awDone, wDone;
    awDone = 0;
    wDone = 0;
    awaddr <= a;
    wdata <= dat;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge mclk);
      if (!awDone && awready === 1'b1) begin
        awDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input string name);
    logic [31:0] x;
    logic [1:0] rs;
    rd(a, x, rs);
    check(name, x & m, exp);
  endtask

  task automatic reportAndStop();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, arvalid} = '0;
    bready = 1'b1; // held high, the slave answers when it likes
    rready = 1'b1;
    lvl = 4'hf;
    strb = 4'hf;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    waitCyc(3);
    // reset values, access kinds, unmapped place
    rdChk(ADDR_CTRL, '1, 32'h0, "ctrl reset");
    rdChk(ADDR_INT_MASK, '1, 32'h0, "mask reset");
    rdChk(ADDR_STAT, 32'h1f, 32'h3, "stat reset");
    wr(ADDR_CTRL, 32'hffffffff, r);
    check("ctrl resp", r, RESP_OKAY);
    rdChk(ADDR_CTRL, '1, 32'h1fff, "ctrl rw");
    // only the strobed byte lane may change
    strb = 4'h2;
    wr(ADDR_CTRL, 32'h0, r);
    strb = 4'hf;
    rdChk(ADDR_CTRL, '1, 32'h00ff, "ctrl lane");
    wr(ADDR_CTRL, 32'h0, r);
    wr(ADDR_STAT, 32'hffffffff, r);
    rdChk(ADDR_STAT, 32'h1f, 32'h3, "stat ro");
    wr(8'h40, 32'h1, r);
    check("unmapped wr", r, RESP_SLVERR);
    rd(8'h40, d, r);
    check("unmapped rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
    // channel 0 drop, recovery and its maskable event
    lvl <= 4'he;
    waitCyc(8);
    check("rst0 low", rst0Req, 1);
    lvl <= 4'hf;
    waitCyc(10);
    check("rst0 hold", rst0Req, 1);
    waitCyc(20);
    check("rst0 rel", rst0Req, 0);
    rdChk(ADDR_INT_STAT, '1, 32'h4, "ch0 event");
    check("irq masked", irq, 0);
    wr(ADDR_INT_MASK, 32'h4, r);
    waitCyc(3);
    check("irq unmasked", irq, 1);
    wr(ADDR_INT_STAT, 32'h4, r);
    waitCyc(3);
    check("irq cleared", irq, 0);
    // channel 1, release counted from recovery, then from the drop
    wr(ADDR_CTRL, 32'h3, r);
    lvl <= 4'hd;
    waitCyc(8);
    check("rst1 low", rst1Req, 1);
    waitCyc(40);
    check("rst1 stays", rst1Req, 1);
    lvl <= 4'hf;
    waitCyc(10);
    check("rst1 hold", rst1Req, 1);
    waitCyc(20);
    check("rst1 rel", rst1Req, 0);
    wr(ADDR_CTRL, 32'h7, r);
    lvl <= 4'hd;
    waitCyc(8);
    check("rst1 drop", rst1Req, 1);
    waitCyc(25);
    check("rst1 rel drop", rst1Req, 0);
    lvl <= 4'hf;
    waitCyc(8);
    lvl <= 4'hd;
    waitCyc(8);
    check("rst1 redrop", rst1Req, 1);
    lvl <= 4'hf;
    waitCyc(30);
    // channel 2 on the external pin: supply dip must not count
    wr(ADDR_CTRL, 32'h130, r);
    lvl <= 4'hb;
    waitCyc(8);
    check("rst2 vcc", rst2Req, 0);
    lvl <= 4'h7;
    waitCyc(8);
    check("rst2 pin", rst2Req, 1);
    rdChk(ADDR_STAT, 32'h1e, 32'h10, "ch2 flag low");
    lvl <= 4'hf;
    waitCyc(30);
    check("rst2 rel", rst2Req, 0);
    rdChk(ADDR_STAT, 32'h2, 32'h2, "ch2 flag high");
    wr(ADDR_CTRL, 32'h170, r);
    lvl <= 4'h7;
    waitCyc(8);
    check("rst2 drop", rst2Req, 1);
    waitCyc(25);
    check("rst2 rel drop", rst2Req, 0);
    lvl <= 4'hf;
    // channel 2 on the supply, release counted from recovery
    wr(ADDR_CTRL, 32'h30, r);
    lvl <= 4'hb;
    waitCyc(8);
    check("rst2 vcc low", rst2Req, 1);
    lvl <= 4'hf;
    waitCyc(30);
    check("rst2 vcc rel", rst2Req, 0);
    wr(ADDR_CTRL, 32'h0, r);
    lvl <= 4'hb;
    waitCyc(8);
    rdChk(ADDR_STAT, 32'h2, 32'h2, "ch2 flag off");
    lvl <= 4'hf;
    waitCyc(8);
    // every trigger code of channel 2, supply source
    for (int c = 0; c < 4; c++) begin
      v = (32'h1 << C2_EN) | (32'(c) << C2_COND);
      wr(ADDR_CTRL, v, r);
      wr(ADDR_INT_STAT, 32'h7, r);
      lvl <= 4'hb;
      waitCyc(8);
      rdChk(ADDR_INT_STAT, 32'h2, (c == 1 || c == 2) ? 32'h2 : 32'h0, "ch2 fall");
      wr(ADDR_INT_STAT, 32'h7, r);
      lvl <= 4'hf;
      waitCyc(8);
      rdChk(ADDR_INT_STAT, 32'h2, (c == 0 || c == 2) ? 32'h2 : 32'h0, "ch2 rise");
    end
    // interrupt routing: non-maskable bypasses the mask, maskable uses it
    wr(ADDR_INT_MASK, 32'h3, r);
    wr(ADDR_INT_STAT, 32'h7, r);
    wr(ADDR_CTRL, 32'h409, r);
    lvl <= 4'hd;
    waitCyc(8);
    check("ch1 nmi", {nmiReq, irq}, 2'b10);
    wr(ADDR_INT_STAT, 32'h7, r);
    wr(ADDR_CTRL, 32'h401, r);
    lvl <= 4'hf;
    waitCyc(8);
    check("ch1 irq", {nmiReq, irq}, 2'b01);
    wr(ADDR_INT_STAT, 32'h7, r);
    wr(ADDR_CTRL, 32'h1098, r); // both channels routed non-maskable
    lvl <= 4'hb;
    waitCyc(8);
    check("ch2 nmi", {nmiReq, irq}, 2'b10);
    lvl <= 4'hf;
    waitCyc(4);
    reportAndStop();
  end
endmodule
